// ### pciu_chan_detect.sv
// Edge comparison of one channel between two consecutive samples
`timescale 1ns/100ps
module pciu_chan_detect (
  input  wire logic sample,
  input  wire logic prevSample,
  input  wire logic cmpValid,
  input  wire logic negEn,
  input  wire logic posEn,
  output logic      edgeHit
);

  logic fallSeen;
  logic riseSeen;

  always_comb begin
    fallSeen = prevSample & ~sample;
    riseSeen = ~prevSample & sample;
    edgeHit  = cmpValid & ((negEn & fallSeen) | (posEn & riseSeen));
  end

endmodule

// ### pciu_checker.sv
// Register bus handshake checks on the pin change interrupt unit ports
`timescale 1ns/100ps
module pciu_checker
  import pciu_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              resetn,
  input wire logic [SYNC_W-1:0] portPins,
  input wire pciu_axil_req_t    axiReq,
  input wire pciu_axil_rsp_t    axiRsp,
  input wire logic              pinIrqReq,
  input wire logic              irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [IDX_W-1:0] rdIdx;
  logic             arTake;
  logic             wrTake;
  logic             rdMapped;
  assign rdIdx    = axiReq.araddr[AXI_ADDR_W-1:2];
  assign arTake   = axiReq.arvalid && axiRsp.arready;
  assign wrTake   = axiReq.awvalid && axiRsp.awready &&
                    axiReq.wvalid && axiRsp.wready;
  assign rdMapped = rdIdx inside {IDX_TYPE_PORT, IDX_FALL_EN, IDX_RISE_EN,
                                  IDX_FLAGS, IDX_IRQ_STATUS, IDX_IRQ_MASK};
  a_read_answer: assert property (
    arTake |=> axiRsp.rvalid)
    else $error("read not answered");
  a_read_unmapped: assert property (
    arTake && !rdMapped |=> axiRsp.rresp == RESP_SLVERR &&
                            axiRsp.rdata == 32'h0)
    else $error("unmapped read not refused");
  a_read_upper: assert property (
    axiRsp.rvalid |-> axiRsp.rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_read_hold: assert property (
    axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata))
    else $error("read data dropped");
  a_read_block: assert property (
    axiRsp.rvalid |-> !axiRsp.arready)
    else $error("second read accepted");
  a_write_answer: assert property (
    wrTake |-> ##[1:2] axiRsp.bvalid)
    else $error("write not answered");
  a_resp_hold: assert property (
    axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp))
    else $error("write response dropped");
  a_write_block: assert property (
    axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
    else $error("second write accepted");
endmodule

bind pciu_top pciu_checker pciu_checker_inst (.sys_clk(sys_clk),
  .resetn(resetn), .portPins(portPins), .axiReq(axiReq), .axiRsp(axiRsp),
  .pinIrqReq(pinIrqReq), .irq(irq));

// ### pciu_pin_model.sv
// External port pins, settling off the bus clock edge
`timescale 1ns/100ps
module pciu_pin_model
  import pciu_pkg::*;
(
  input wire logic [SYNC_W-1:0] pinTarget,
  output logic     [SYNC_W-1:0] portPins
);
  // Asynchronous to the clock so the synchroniser sees real skew
  assign #37 portPins = pinTarget;
endmodule

// ### pciu_pkg.sv
// Shared constants, register map and bus carriers of the pin change interrupt unit
package pciu_pkg;

  localparam int unsigned AXI_ADDR_W = 12;
  localparam int unsigned IDX_W      = AXI_ADDR_W - 2;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_TYPE_PORT  = 10'h0e9;
  localparam logic [IDX_W-1:0] IDX_FALL_EN    = 10'h0ea;
  localparam logic [IDX_W-1:0] IDX_RISE_EN    = 10'h0eb;
  localparam logic [IDX_W-1:0] IDX_FLAGS      = 10'h0ec;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h040;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK   = 10'h041;

  // Fields of the type and port select register
  localparam int unsigned TYPE_CH67_BIT = 7;
  localparam int unsigned TYPE_CH45_BIT = 6;
  localparam int unsigned TYPE_CH3_BIT  = 5;
  localparam int unsigned TYPE_CH2_BIT  = 4;
  localparam int unsigned TYPE_CH1_BIT  = 3;
  localparam int unsigned TYPE_CH0_BIT  = 2;
  localparam int unsigned PORT_SEL_LSB  = 0;
  localparam int unsigned PORT_SEL_W    = 2;

  localparam logic [1:0] PORT_0 = 2'h0;
  localparam logic [1:0] PORT_1 = 2'h1;
  localparam logic [1:0] PORT_2 = 2'h2;
  localparam logic [1:0] PORT_3 = 2'h3;

  localparam int unsigned CHANNELS  = 8;
  localparam int unsigned PORTS     = 4;
  localparam int unsigned SYNC_W    = CHANNELS * PORTS;

  // Reset values
  localparam logic [7:0] TYPE_PORT_RST  = 8'h00;
  localparam logic [7:0] FALL_EN_RST    = 8'h00;
  localparam logic [7:0] RISE_EN_RST    = 8'h00;
  localparam logic [7:0] FLAGS_RST      = 8'h00;
  localparam logic [7:0] IRQ_STATUS_RST = 8'h00;
  localparam logic [7:0] IRQ_MASK_RST   = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic                  awvalid;
    logic [AXI_ADDR_W-1:0] awaddr;
    logic                  wvalid;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bready;
    logic                  arvalid;
    logic [AXI_ADDR_W-1:0] araddr;
    logic                  rready;
  } pciu_axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pciu_axil_rsp_t;

endpackage

// ### pciu_sync.sv
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/100ps
module pciu_sync #(
  parameter int unsigned WIDTH = 32
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } pciu_sync_state_t;

  pciu_sync_state_t state_reg;
  pciu_sync_state_t state_next;

  always_comb begin
    state_next        = state_reg;
    state_next.stage1 = asyncIn;
    state_next.stage2 = state_reg.stage1;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign syncOut = state_reg.stage2;

endmodule

// ### pciu_top.sv
// Pin change interrupt unit with AXI4-Lite register access
//
// Contract
// - Type bit 7 picks level or edge for channels six and seven.
// - Type bit 6 picks level or edge for channels four and five.
// - Type bits 5 to 2 pick level or edge for channels 3 to 0.
// - Port select bits 1:0 route port 0 to 3 onto the channels.
// - Falling enable bit arms low level or falling edge detection per channel; the code uses it in edge mode only.
// - Rising enable bit arms high level or rising edge detection per channel; the code uses it in edge mode only, and level mode always flags a low level.
// - Edge mode: an enabled edge sets the flag, which stays until written.
// - Level mode: flag is the inverted pin level, read only.
// - Type/port, rising enable and flag registers reset to zero.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module pciu_top
  import pciu_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic [SYNC_W-1:0] portPins,
  input  wire pciu_axil_req_t    axiReq,
  output pciu_axil_rsp_t         axiRsp,
  output logic                   pinIrqReq,
  output logic                   irq
);

  typedef struct packed {
    logic             awDone;
    logic [IDX_W-1:0] wrIdx;
    logic             wDone;
    logic [7:0]       wrData;
    logic             wrStrb;
    pciu_axil_rsp_t   rsp;
    logic [7:0]       typePort;
    logic [7:0]       fallEn;
    logic [7:0]       riseEn;
    logic [7:0]       flags;
    logic [7:0]       irqStatus;
    logic [7:0]       irqMask;
    logic [7:0]       prevSample;
    logic [1:0]       prevPort;
    logic             primed;
    logic             warm;
    logic             pinIrqReq;
    logic             irq;
  } pciu_state_t;

  pciu_state_t state_reg;
  pciu_state_t state_next;

  logic [SYNC_W-1:0]   syncPins;
  logic [CHANNELS-1:0] curSample;
  logic [CHANNELS-1:0] edgeMode;
  logic [CHANNELS-1:0] edgeHit;
  logic [1:0]          portSel;
  logic                cmpValid;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and per-channel edge detection

  pciu_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .asyncIn (portPins),
    .syncOut (syncPins)
  );

  always_comb begin
    portSel = state_reg.typePort[PORT_SEL_LSB +: PORT_SEL_W];
    unique case (portSel)
      PORT_0:  curSample = syncPins[0*CHANNELS +: CHANNELS];
      PORT_1:  curSample = syncPins[1*CHANNELS +: CHANNELS];
      PORT_2:  curSample = syncPins[2*CHANNELS +: CHANNELS];
      PORT_3:  curSample = syncPins[3*CHANNELS +: CHANNELS];
    endcase
    // A port switch would show as a false edge; skip that one compare
    cmpValid = state_reg.primed && (state_reg.prevPort == portSel);
    edgeMode = {state_reg.typePort[TYPE_CH67_BIT],
                state_reg.typePort[TYPE_CH67_BIT],
                state_reg.typePort[TYPE_CH45_BIT],
                state_reg.typePort[TYPE_CH45_BIT],
                state_reg.typePort[TYPE_CH3_BIT],
                state_reg.typePort[TYPE_CH2_BIT],
                state_reg.typePort[TYPE_CH1_BIT],
                state_reg.typePort[TYPE_CH0_BIT]};
  end

  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    pciu_chan_detect u_detect (
      .sample     (curSample[ch]),
      .prevSample (state_reg.prevSample[ch]),
      .cmpValid   (cmpValid),
      .negEn      (state_reg.fallEn[ch]),
      .posEn      (state_reg.riseEn[ch]),
      .edgeHit    (edgeHit[ch])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave, registers, flags and interrupt

  logic             doWrite;
  logic             wrMapped;
  logic             wrFlags;
  logic [7:0]       statusClr;
  logic [IDX_W-1:0] rdIdx;
  logic [7:0]       rdByte;
  logic             rdMapped;

  always_comb begin
    state_next = state_reg;
    wrMapped   = 1'b0;
    wrFlags    = 1'b0;
    statusClr  = 8'h00;
    rdByte     = 8'h00;
    rdMapped   = 1'b1;
    rdIdx      = axiReq.araddr[AXI_ADDR_W-1:2];

    if (axiReq.awvalid && state_reg.rsp.awready) begin
      state_next.awDone = 1'b1;
      state_next.wrIdx  = axiReq.awaddr[AXI_ADDR_W-1:2];
    end
    if (axiReq.wvalid && state_reg.rsp.wready) begin
      state_next.wDone  = 1'b1;
      state_next.wrData = axiReq.wdata[7:0];
      state_next.wrStrb = axiReq.wstrb[0];
    end
    if (state_reg.rsp.bvalid && axiReq.bready) begin
      state_next.rsp.bvalid = 1'b0;
    end

    doWrite = state_reg.awDone && state_reg.wDone && !state_reg.rsp.bvalid;
    if (doWrite) begin
      state_next.awDone     = 1'b0;
      state_next.wDone      = 1'b0;
      state_next.rsp.bvalid = 1'b1;
      unique case (state_reg.wrIdx)
        IDX_TYPE_PORT, IDX_FALL_EN, IDX_RISE_EN, IDX_FLAGS,
        IDX_IRQ_STATUS, IDX_IRQ_MASK: wrMapped = 1'b1;
        default:                      wrMapped = 1'b0;
      endcase
      state_next.rsp.bresp = wrMapped ? RESP_OKAY : RESP_SLVERR;
      if (wrMapped && state_reg.wrStrb) begin
        unique case (state_reg.wrIdx)
          IDX_TYPE_PORT:  state_next.typePort = state_reg.wrData;
          IDX_FALL_EN:    state_next.fallEn   = state_reg.wrData;
          IDX_RISE_EN:    state_next.riseEn   = state_reg.wrData;
          IDX_FLAGS:      wrFlags             = 1'b1;
          IDX_IRQ_STATUS: statusClr           = state_reg.wrData;
          IDX_IRQ_MASK:   state_next.irqMask  = state_reg.wrData;
          default:        wrFlags             = 1'b0;
        endcase
      end
    end
    state_next.rsp.awready = !state_next.awDone && !state_next.rsp.bvalid;
    state_next.rsp.wready  = !state_next.wDone && !state_next.rsp.bvalid;

    if (state_reg.rsp.rvalid && axiReq.rready) begin
      state_next.rsp.rvalid = 1'b0;
    end
    if (axiReq.arvalid && state_reg.rsp.arready) begin
      unique case (rdIdx)
        IDX_TYPE_PORT:  rdByte = state_reg.typePort;
        IDX_FALL_EN:    rdByte = state_reg.fallEn;
        IDX_RISE_EN:    rdByte = state_reg.riseEn;
        IDX_FLAGS:      rdByte = state_reg.flags;
        IDX_IRQ_STATUS: rdByte = state_reg.irqStatus;
        IDX_IRQ_MASK:   rdByte = state_reg.irqMask;
        default:        rdMapped = 1'b0;
      endcase
      state_next.rsp.rvalid = 1'b1;
      state_next.rsp.rdata  = {24'h000000, rdByte};
      state_next.rsp.rresp  = rdMapped ? RESP_OKAY : RESP_SLVERR;
    end
    state_next.rsp.arready = !state_next.rsp.rvalid;

    // Channel flags; in edge mode a hit wins over a same-cycle write
    for (int ch = 0; ch < CHANNELS; ch++) begin
      if (edgeMode[ch]) begin
        state_next.flags[ch] = (wrFlags ? state_reg.wrData[ch]
                                        : state_reg.flags[ch])
                               | edgeHit[ch];
      end else begin
        // Hold reset flags until the synchroniser carries real pin levels
        state_next.flags[ch] = state_reg.warm ? ~curSample[ch]
                                              : state_reg.flags[ch];
      end
    end

    state_next.prevSample = curSample;
    state_next.prevPort   = portSel;
    state_next.primed     = 1'b1;
    state_next.warm       = state_reg.primed;

    // Sticky status: an active flag wins over a write-one clear
    state_next.irqStatus = (state_reg.irqStatus & ~statusClr)
                           | state_reg.flags;
    state_next.pinIrqReq = |state_next.flags;
    state_next.irq       = |(state_next.irqStatus & state_next.irqMask);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg           <= '0;
      state_reg.typePort  <= TYPE_PORT_RST;
      state_reg.fallEn    <= FALL_EN_RST;
      state_reg.riseEn    <= RISE_EN_RST;
      state_reg.flags     <= FLAGS_RST;
      state_reg.irqStatus <= IRQ_STATUS_RST;
      state_reg.irqMask   <= IRQ_MASK_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign axiRsp    = state_reg.rsp;
  assign pinIrqReq = state_reg.pinIrqReq;
  assign irq       = state_reg.irq;

endmodule

// ### test_pciu_top.sv
// Self-checking bench of the pin change interrupt unit
`timescale 1ns/100ps
module test_pciu_top
  import pciu_pkg::*;
;
  logic              sys_clk = 1'b0;
  logic              resetn = 1'b0;
  logic [SYNC_W-1:0] pinTarget = 32'hffffffff;
  logic [SYNC_W-1:0] portPins;
  pciu_axil_req_t    axiReq = '0;
  pciu_axil_rsp_t    axiRsp;
  logic              pinIrqReq;
  logic              irq;
  int                n_errors = 0;
  int                check_count = 0;
  logic [31:0]       pat = 32'h96c3a50f;
  logic [7:0]        tmask [6] = '{8'h01, 8'h02, 8'h04, 8'h08,
                                   8'h30, 8'hc0};
  always #50 sys_clk = ~sys_clk;
  pciu_top pciu_top_inst (.sys_clk(sys_clk), .resetn(resetn),
    .portPins(portPins), .axiReq(axiReq), .axiRsp(axiRsp),
    .pinIrqReq(pinIrqReq), .irq(irq));
  pciu_pin_model pciu_pin_model_inst (.pinTarget(pinTarget),
    .portPins(portPins));
  task automatic summarize;
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic guard(input int n);
    if (n >= 50) begin
      n_errors++;
      summarize();
    end
  endtask
  task automatic settle;
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= {idx, 2'h0};
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= {24'h0, d};
    axiReq.wstrb <= 4'hf;
    axiReq.bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (axiRsp.awready === 1'b1) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready === 1'b1) axiReq.wvalid <= 1'b0;
    end while (axiRsp.bvalid !== 1'b1 && n < 50);
    guard(n);
    chk({30'h0, axiRsp.bresp}, {30'h0, RESP_OKAY});
  endtask
  task automatic rd(input logic [IDX_W-1:0] idx, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= {idx, 2'h0};
    axiReq.rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (axiRsp.arready === 1'b1) axiReq.arvalid <= 1'b0;
    end while (axiRsp.rvalid !== 1'b1 && n < 50);
    d = axiRsp.rdata;
    r = axiRsp.rresp;
    guard(n);
  endtask
  task automatic rchk(input logic [IDX_W-1:0] idx, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(idx, d, r);
    chk(d, {24'h0, e});
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  task automatic reset_values;
    logic [31:0] d;
    logic [1:0]  r;
    rchk(IDX_TYPE_PORT, 8'h00);
    rchk(IDX_RISE_EN, 8'h00);
    rchk(IDX_FLAGS, 8'h00);
    rchk(IDX_FALL_EN, FALL_EN_RST);
    rchk(IDX_IRQ_MASK, 8'h00);
    rchk(IDX_IRQ_STATUS, 8'h00);
    chk({31'h0, pinIrqReq}, 32'h0);
    rd(10'h3ff, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
  endtask
  task automatic port_level;
    pinTarget <= pat;
    for (int p = 0; p < 4; p++) begin
      wr(IDX_TYPE_PORT, 8'(p));
      settle();
      rchk(IDX_FLAGS, ~pat[8*p +: 8]);
    end
    wr(IDX_FLAGS, 8'h00);
    settle();
    rchk(IDX_FLAGS, ~pat[31:24]);
    chk({31'h0, pinIrqReq}, 32'h1);
    pinTarget <= 32'hffffffff;
  endtask
  task automatic type_bits;
    wr(IDX_FALL_EN, 8'hff);
    wr(IDX_RISE_EN, 8'hff);
    for (int b = 2; b < 8; b++) begin
      wr(IDX_TYPE_PORT, 8'h01 << b);
      wr(IDX_FLAGS, 8'h00);
      pinTarget[7:0] <= 8'h00;
      settle();
      pinTarget[7:0] <= 8'hff;
      settle();
      rchk(IDX_FLAGS, tmask[b-2]);
    end
  endtask
  task automatic polarity_irq;
    wr(IDX_TYPE_PORT, 8'hfc);
    wr(IDX_FALL_EN, 8'h0f);
    wr(IDX_RISE_EN, 8'hf0);
    wr(IDX_FLAGS, 8'h00);
    settle();
    chk({31'h0, pinIrqReq}, 32'h0);
    pinTarget[7:0] <= 8'h00;
    settle();
    rchk(IDX_FLAGS, 8'h0f);
    pinTarget[7:0] <= 8'hff;
    settle();
    rchk(IDX_FLAGS, 8'hff);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_IRQ_MASK, 8'h08);
    settle();
    chk({31'h0, irq}, 32'h1);
    wr(IDX_FLAGS, 8'h0a);
    rchk(IDX_FLAGS, 8'h0a);
    wr(IDX_FLAGS, 8'h00);
    wr(IDX_IRQ_STATUS, 8'hff);
    settle();
    chk({31'h0, irq}, 32'h0);
    rchk(IDX_IRQ_STATUS, 8'h00);
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset_values();
    port_level();
    type_bits();
    polarity_irq();
    summarize();
  end
endmodule
